// [rtl/dsf_status_flags.sv]
// Status flag word and extended command word of the dispenser controller
`timescale 1ns/1ps
module dsf_status_flags
  import dsf_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [31:0] command_word,
  input wire logic [31:0] extended_command_parameter,
  input wire dsf_pkg::dsf_cond_type cond,
  input wire dsf_pkg::dsf_disp_type disp,
  input wire logic [15:0] post_dwell,
  output logic [31:0] status_flag_parameter,
  output logic clear_fault_pulse,
  output logic start_prod_pulse,
  output logic ext_cmd_misuse
);
  import dsf_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [31:0] cmd_s1_r;
  logic [31:0] cmd_s2_r;
  logic [31:0] cmd_prev_r;
  logic [31:0] ext_s1_r;
  logic [31:0] ext_s2_r;
  dsf_cond_type cond_s1_r;
  dsf_cond_type cond_s2_r;
  dsf_disp_type disp_s1_r;
  dsf_disp_type disp_s2_r;
  dsf_disp_type disp_prev_r;

  // Two-stage capture of all external inputs except post_dwell
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cmd_s1_r <= 32'h0000_0000;
      cmd_s2_r <= 32'h0000_0000;
      cmd_prev_r <= 32'h0000_0000;
      ext_s1_r <= EXT_CMD_RST;
      ext_s2_r <= EXT_CMD_RST;
      cond_s1_r <= '0;
      cond_s2_r <= '0;
      disp_s1_r <= '0;
      disp_s2_r <= '0;
      disp_prev_r <= '0;
    end
    else
    begin
      cmd_s1_r <= command_word;
      cmd_s2_r <= cmd_s1_r;
      cmd_prev_r <= cmd_s2_r;
      ext_s1_r <= extended_command_parameter;
      ext_s2_r <= ext_s1_r;
      cond_s1_r <= cond;
      cond_s2_r <= cond_s1_r;
      disp_s1_r <= disp;
      disp_s2_r <= disp_s1_r;
      disp_prev_r <= disp_s2_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Initialization and fault state

  logic [3:0] init_cnt_r;
  logic [3:0] init_cnt_nxt;
  logic init_r;
  logic init_nxt;
  logic fault_r;
  logic fault_nxt;
  logic clr_edge;
  logic prod_edge;
  logic ok_edge;
  logic bad_edge;

  assign clr_edge = cmd_s2_r[CMD_CLEAR_FAULT] & ~cmd_prev_r[CMD_CLEAR_FAULT];
  assign prod_edge = cmd_s2_r[CMD_START_PROD] & ~cmd_prev_r[CMD_START_PROD];
  assign ok_edge = disp_s2_r.done_ok & ~disp_prev_r.done_ok;
  assign bad_edge = disp_s2_r.done_bad & ~disp_prev_r.done_bad;

  // Init count-up to INIT_CYCLES, fault latch with set priority over clear
  always_comb
  begin
    init_cnt_nxt = init_cnt_r;
    init_nxt = init_r;
    if (!init_r)
    begin
      if (init_cnt_r == INIT_CYCLES)
        init_nxt = 1'b1;
      else
        init_cnt_nxt = init_cnt_r + 4'h1;
    end
    fault_nxt = fault_r;
    if (clr_edge && fault_r)
      fault_nxt = 1'b0;
    if (cond_s2_r.fault)
      fault_nxt = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Status word assembly

  logic [31:0] stat_r;
  logic [31:0] stat_nxt;
  logic last_ok_r;
  logic last_ok_nxt;
  logic clr_r;
  logic clr_nxt;
  logic prod_r;
  logic prod_nxt;
  logic misuse_r;
  logic misuse_nxt;
  logic pulse_on;
  logic any_busy;
  logic blocked;
  logic idle_ok;

  dsf_dwell_timer u_dwell
  (
    .clock(clock),
    .resetn(resetn),
    .start(ok_edge),
    .dwell(post_dwell),
    .active(pulse_on)
  );

  always_comb
  begin
    any_busy = |cond_s2_r.busy;
    blocked = fault_r | cond_s2_r.ref_req | cond_s2_r.load_req
      | cond_s2_r.port_req;
    idle_ok = init_r & cond_s2_r.configured & ~fault_r
      & ~cond_s2_r.motion_dis & ~any_busy;
    last_ok_nxt = last_ok_r;
    if (bad_edge)
      last_ok_nxt = 1'b0;
    else if (ok_edge)
      last_ok_nxt = 1'b1;
    stat_nxt = STATUS_RST;
    stat_nxt[BIT_INIT] = init_r;
    stat_nxt[BIT_CONFIG] = cond_s2_r.configured;
    stat_nxt[BIT_FAULT] = fault_r;
    stat_nxt[BIT_ALERT] = cond_s2_r.alert;
    stat_nxt[BIT_MOT_DIS] = cond_s2_r.motion_dis;
    stat_nxt[BIT_REF_REQ] = cond_s2_r.ref_req;
    stat_nxt[BIT_LOAD_REQ] = cond_s2_r.load_req;
    stat_nxt[BIT_PORT_REQ] = cond_s2_r.port_req;
    stat_nxt[BIT_RDY_IDLE] = idle_ok;
    stat_nxt[BIT_RDY_PROD] = idle_ok & ~blocked & ~cond_s2_r.parked;
    stat_nxt[BIT_RDY_FLU] = idle_ok & ~cond_s2_r.ref_req
      & ~cond_s2_r.parked;
    stat_nxt[BIT_RDY_REF] = idle_ok;
    stat_nxt[BIT_RDY_LOAD] = idle_ok & ~cond_s2_r.ref_req
      & ~cond_s2_r.parked;
    stat_nxt[BIT_RDY_PARK] = idle_ok & ~cond_s2_r.ref_req
      & ~cond_s2_r.parked;
    stat_nxt[BIT_RDY_UNPARK] = idle_ok & cond_s2_r.parked;
    stat_nxt[BIT_BUSY_REQ] = blocked;
    stat_nxt[BIT_BUSY_ANY] = any_busy;
    stat_nxt[BIT_BUSY_PROD] = cond_s2_r.busy.prod;
    stat_nxt[BIT_BUSY_FLU] = cond_s2_r.busy.fluidic;
    stat_nxt[BIT_BUSY_REF] = cond_s2_r.busy.refer;
    stat_nxt[BIT_BUSY_LOAD] = cond_s2_r.busy.load;
    stat_nxt[BIT_BUSY_PORT] = cond_s2_r.busy.port;
    stat_nxt[BIT_BUSY_PARK] = cond_s2_r.busy.park;
    stat_nxt[BIT_BUSY_AUTO] = cond_s2_r.busy.autotrig;
    stat_nxt[BIT_PARKED] = cond_s2_r.parked;
    stat_nxt[BIT_CH_FULL] = cond_s2_r.chamber_full;
    stat_nxt[BIT_SUCC_PULSE] = pulse_on;
    stat_nxt[BIT_SUCC_LAST] = last_ok_r;
    clr_nxt = clr_edge & fault_r;
    prod_nxt = prod_edge & stat_r[BIT_RDY_PROD];
    misuse_nxt = |ext_s2_r;
  end

  // State and output registers
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      init_cnt_r <= 4'h0;
      init_r <= 1'b0;
      fault_r <= 1'b0;
      last_ok_r <= 1'b0;
      stat_r <= STATUS_RST;
      clr_r <= 1'b0;
      prod_r <= 1'b0;
      misuse_r <= 1'b0;
    end
    else
    begin
      init_cnt_r <= init_cnt_nxt;
      init_r <= init_nxt;
      fault_r <= fault_nxt;
      last_ok_r <= last_ok_nxt;
      stat_r <= stat_nxt;
      clr_r <= clr_nxt;
      prod_r <= prod_nxt;
      misuse_r <= misuse_nxt;
    end
  end

  assign status_flag_parameter = stat_r;
  assign clear_fault_pulse = clr_r;
  assign start_prod_pulse = prod_r;
  assign ext_cmd_misuse = misuse_r;

endmodule

// [pkg/dsf_pkg.sv]
// Package with status word layout, command layout and shared types
package dsf_pkg;

  // Status word bit positions
  localparam int BIT_INIT = 0;
  localparam int BIT_CONFIG = 1;
  localparam int BIT_FAULT = 2;
  localparam int BIT_ALERT = 3;
  localparam int BIT_MOT_DIS = 4;
  localparam int BIT_REF_REQ = 5;
  localparam int BIT_LOAD_REQ = 6;
  localparam int BIT_PORT_REQ = 7;
  localparam int BIT_RDY_IDLE = 8;
  localparam int BIT_RDY_PROD = 9;
  localparam int BIT_RDY_FLU = 10;
  localparam int BIT_RDY_REF = 11;
  localparam int BIT_RDY_LOAD = 12;
  localparam int BIT_RDY_PARK = 13;
  localparam int BIT_RDY_UNPARK = 14;
  localparam int BIT_BUSY_REQ = 15;
  localparam int BIT_BUSY_ANY = 16;
  localparam int BIT_BUSY_PROD = 17;
  localparam int BIT_BUSY_FLU = 18;
  localparam int BIT_BUSY_REF = 19;
  localparam int BIT_BUSY_LOAD = 20;
  localparam int BIT_BUSY_PORT = 21;
  localparam int BIT_BUSY_PARK = 22;
  localparam int BIT_BUSY_AUTO = 23;
  localparam int BIT_PARKED = 24;
  localparam int BIT_CH_FULL = 25;
  localparam int BIT_SUCC_PULSE = 26;
  localparam int BIT_SUCC_LAST = 27;

  // Command word bit positions
  localparam int CMD_START_PROD = 2;
  localparam int CMD_CLEAR_FAULT = 5;

  // Reset values and init cycle count
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] EXT_CMD_RST = 32'h0000_0000;
  localparam logic [15:0] DWELL_RST = 16'h0000;
  localparam logic [3:0] INIT_CYCLES = 4'hF;

  // Operation categories reported as busy
  typedef struct packed {
    logic autotrig;
    logic park;
    logic port;
    logic load;
    logic refer;
    logic fluidic;
    logic prod;
  } dsf_busy_type;

  // Conditions fed in by the operation sequencer
  typedef struct packed {
    logic configured;
    logic fault;
    logic alert;
    logic motion_dis;
    logic ref_req;
    logic load_req;
    logic port_req;
    logic parked;
    logic chamber_full;
    dsf_busy_type busy;
  } dsf_cond_type;

  // Dispense completion events
  typedef struct packed {
    logic done_ok;
    logic done_bad;
  } dsf_disp_type;

endpackage

// [rtl/dsf_dwell_timer.sv]
// Post-operation dwell timer driving the success pulse
`timescale 1ns/1ps
module dsf_dwell_timer
  import dsf_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  input wire logic [15:0] dwell,
  output logic active
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic active_r;
  logic active_nxt;

  // Load on start, count down to zero
  always_comb
  begin
    cnt_nxt = cnt_r;
    active_nxt = active_r;
    if (start)
    begin
      cnt_nxt = (dwell == DWELL_RST) ? 16'h0001 : dwell;
      active_nxt = 1'b1;
    end
    else if (active_r)
    begin
      cnt_nxt = cnt_r - 16'h0001;
      active_nxt = (cnt_r != 16'h0001);
    end
  end

  // Timer registers
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cnt_r <= DWELL_RST;
      active_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      active_r <= active_nxt;
    end
  end

  assign active = active_r;

endmodule

// [tb/dsf_plc_model.sv]
// Supervising controller model that produces command edges
`timescale 1ns/1ps
module dsf_plc_model
  import dsf_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic fire,
  input wire logic [4:0] sel,
  input wire logic ext_bad,
  output logic [31:0] command_word,
  output logic [31:0] extended_command_parameter
);
  logic [3:0] hold_r;
  logic [4:0] sel_r;
  // Count out a high phase of four cycles and a low phase of four
  always_ff @(posedge clock)
  begin
    if (!resetn)
      hold_r <= 4'h0;
    else if (fire)
    begin
      hold_r <= 4'h8;
      sel_r <= sel;
    end
    else if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
  end
  assign command_word = (hold_r > 4'h4) ? (32'h1 << sel_r) : 32'h0;
  assign extended_command_parameter = ext_bad ? 32'h1 : 32'h0;
endmodule

// [tb/dsf_status_chk.sv]
// Checker with assertions on the status flag word
`timescale 1ns/1ps
module dsf_status_chk
  import dsf_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [31:0] command_word,
  input wire logic [31:0] extended_command_parameter,
  input wire dsf_pkg::dsf_cond_type cond,
  input wire dsf_pkg::dsf_disp_type disp,
  input wire logic [15:0] post_dwell,
  input wire logic [31:0] status_flag_parameter,
  input wire logic clear_fault_pulse,
  input wire logic start_prod_pulse,
  input wire logic ext_cmd_misuse
);
  logic [4:0] run_r;
  logic [4:0] run_nxt;
  logic [31:0] sf;
  assign sf = status_flag_parameter;
  // Edges since reset release, saturating
  always_comb
  begin
    run_nxt = (run_r == 5'h1F) ? run_r : run_r + 5'h01;
    if (!resetn)
      run_nxt = 5'h00;
  end
  always_ff @(posedge clock)
  begin
    run_r <= run_nxt;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_ok;
    run_r > 5'h03 && $rose(disp.done_ok) && !disp.done_bad;
  endsequence
  property p_cfg;
    run_r > 5'h03 |-> sf[1] == $past(cond.configured, 3);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config flag");
  property p_flags;
    run_r > 5'h03 |-> sf[7:3] == $past({cond.port_req, cond.load_req,
      cond.ref_req, cond.motion_dis, cond.alert}, 3);
  endproperty
  a_flags: assert property (p_flags) else $error("flags");
  property p_busy;
    run_r > 5'h03 |-> sf[23:17] == $past(cond.busy, 3);
  endproperty
  a_busy: assert property (p_busy) else $error("busy flags");
  property p_any;
    run_r > 5'h03 |-> sf[16] == (|$past(cond.busy, 3));
  endproperty
  a_any: assert property (p_any) else $error("busy any");
  property p_park;
    run_r > 5'h03 |-> sf[25:24] == $past({cond.chamber_full, cond.parked}, 3);
  endproperty
  a_park: assert property (p_park) else $error("parked or full");
  property p_init_lo;
    run_r < 5'h0E |-> !sf[0];
  endproperty
  a_init_lo: assert property (p_init_lo) else $error("init early");
  property p_init_hi;
    run_r == 5'h18 |-> sf[0];
  endproperty
  a_init_hi: assert property (p_init_hi) else $error("init late");
  property p_ok;
    s_ok |-> ##[2:6] sf[27];
  endproperty
  a_ok: assert property (p_ok) else $error("success latch");
  property p_clr;
    clear_fault_pulse |=> !clear_fault_pulse;
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse long");
  // Fault seen four edges back must show in the word
  property p_fault;
    run_r > 5'h04 && $past(cond.fault, 4) |-> sf[2];
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag");
  // Start pulse only follows a ready word
  property p_prod;
    start_prod_pulse |-> $past(sf[9]);
  endproperty
  a_prod: assert property (p_prod) else $error("start not ready");
  // Misuse flag tracks the extended command word
  property p_misuse;
    run_r > 5'h03 |-> ext_cmd_misuse ==
      (|$past(extended_command_parameter, 3));
  endproperty
  a_misuse: assert property (p_misuse) else $error("ext misuse");
endmodule
bind dsf_status_flags dsf_status_chk u_chk (.clock(clock), .resetn(resetn),
  .command_word(command_word), .cond(cond), .disp(disp),
  .extended_command_parameter(extended_command_parameter),
  .post_dwell(post_dwell), .status_flag_parameter(status_flag_parameter),
  .clear_fault_pulse(clear_fault_pulse), .start_prod_pulse(start_prod_pulse),
  .ext_cmd_misuse(ext_cmd_misuse));

// [tb/testbench.sv]
// Self-checking bench for the status flag word
`timescale 1ns/1ps
module testbench;
  import dsf_pkg::*;
  logic clock, resetn, fire, ext_bad, clr_p, prod_p, misuse;
  logic [4:0] sel;
  logic [31:0] cmd_w, ext_w, sf;
  logic [15:0] rnd, dw;
  dsf_cond_type cond, v;
  dsf_disp_type disp;
  int fail_count, check_count, nc, np, hi;
  dsf_status_flags u_dsf_status_flags (.clock(clock), .resetn(resetn),
    .command_word(cmd_w), .extended_command_parameter(ext_w), .cond(cond),
    .disp(disp), .post_dwell(dw), .status_flag_parameter(sf),
    .clear_fault_pulse(clr_p), .start_prod_pulse(prod_p),
    .ext_cmd_misuse(misuse));
  dsf_plc_model u_dsf_plc_model (.clock(clock), .resetn(resetn),
    .fire(fire), .sel(sel), .ext_bad(ext_bad), .command_word(cmd_w),
    .extended_command_parameter(ext_w));
  // Random source and expected level flags
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] exp_sf(input dsf_cond_type c);
    return {6'h00, c.chamber_full, c.parked, c.busy, 9'h000, c.port_req,
      c.load_req, c.ref_req, c.motion_dis, c.alert, 1'b0, c.configured, 1'b0};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hold8;
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic set_cond(input dsf_cond_type c);
    @(posedge clock);
    cond <= c;
    hold8;
  endtask
  // Issue one command edge and count the answering pulses
  task automatic cmd(input int b);
    nc = 0;
    np = 0;
    @(posedge clock);
    fire <= 1'b1;
    sel <= 5'(b);
    @(posedge clock);
    fire <= 1'b0;
    repeat (14)
    begin
      @(negedge clock);
      nc += clr_p;
      np += prod_p;
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    repeat (6000) @(posedge clock);
    fail_count++;
    end_sim;
  end
  initial
  begin
    {resetn, fire, ext_bad, sel, cond, disp} = '0;
    dw = 16'h0001;
    rnd = 16'h8C47;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(negedge clock);
    check(sf[0], 32'h0);
    repeat (30) @(negedge clock);
    check(sf[0], 32'h1);
    for (int i = 0; i < 24; i++)
    begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 16'hBFFF : (i == 1) ? 16'h0000 : rnd & 16'hBFFF;
      set_cond(v);
      check(sf & 32'h03FE00FA, exp_sf(v));
    end
    set_cond(16'h8100);
    check(sf[15:8], 32'h49);
    set_cond(16'h8800);
    check(sf[15:8], 32'h89);
    set_cond(16'h8000);
    check(sf[9:8], 32'h3);
    check(sf[15:10], 32'h0F);
    cmd(CMD_START_PROD);
    check(np, 32'h1);
    set_cond(16'h9000);
    check(sf[9], 32'h0);
    cmd(CMD_START_PROD);
    check(np, 32'h0);
    set_cond(16'hC000);
    check(sf[2], 32'h1);
    check(sf[15], 32'h1);
    set_cond(16'h8000);
    check(sf[2], 32'h1);
    cmd(CMD_CLEAR_FAULT);
    check(nc, 32'h1);
    check(sf[2], 32'h0);
    cmd(CMD_CLEAR_FAULT);
    check(nc, 32'h0);
    @(posedge clock);
    dw <= 16'(rnd[2:0]) + 16'h0002;
    disp <= 2'b10;
    hi = 0;
    repeat (30)
    begin
      @(negedge clock);
      hi += sf[26];
    end
    check(hi, 32'(dw));
    check(sf[27], 32'h1);
    @(posedge clock);
    disp <= 2'b01;
    hold8;
    check(sf[27], 32'h0);
    @(posedge clock);
    ext_bad <= 1'b1;
    hold8;
    check(misuse, 32'h1);
    @(posedge clock);
    ext_bad <= 1'b0;
    hold8;
    check(misuse, 32'h0);
    end_sim;
  end
endmodule
